// ==== src/ctm_pkg.sv ====
// package for the compact 10-bit timer: register map, fields, encodings
// Contract
// - pause bit set stops counting, module stays powered; clearing resumes counting
// - pause holds the counter value; counting resumes from that held value
// - clock select 000 sys/4, 001 sys, 010 high/16, 011 high/64, 100 tbc, 110/111 pin edges
// - on bit 1 runs the counter; 0 stops counting and powers off
// - on bit rising clears counter; falling keeps counter value
// - compare mode: on bit rising restores output to initial level
// - period value compared to counter bits 9..7; 000 means 1024 clocks
// - period value zero lets the counter run to maximum and overflow
// - mode 00 compare output, 01 undefined, 10 pwm, 11 timer/counter
// - compare mode output function on match A: none, low, high, toggle
// - requested level equal to initial level gives no visible pin change
// - pwm output function: 00 inactive, 01 active, 10 waveform, 11 undefined
// - compare mode initial level bit: 0 low, 1 high; unused in timer mode
// - pwm mode initial level bit selects active level: 0 low, 1 high
// - invert bit inverts output pin; ignored in timer/counter mode
// - swap bit 0: period value period, compare duty; 1 reversed
// - clear select 1 clears on match A; 0 on match P or overflow
// - overflow clear only when period value zero; clear select ignored in pwm
// - counter readable only, low byte bits 7..0, high byte bits 9..8
// - compare low write goes to buffer; high write loads both bytes together
// - high byte read copies low byte into buffer; low read returns buffer
// - compare mode output changes only on match A flag, not match P
// - counter clears by overflow or match raise a timer flag; here overflow raises no flag, only match A and match P set one
package ctm_pkg;
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_FLAGS = 3'h6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [2:0] PERIOD_OVF = 3'h0;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  typedef enum logic [2:0] {
    CK_SYS_DIV4, CK_SYS, CK_HIGH_DIV16, CK_HIGH_DIV64,
    CK_TBC, CK_UNDEF, CK_PIN_RISE, CK_PIN_FALL
  } clk_sel_t;

  typedef enum logic [1:0] {MODE_CMP, MODE_UNDEF, MODE_PWM, MODE_TIMER} mode_t;

  typedef struct packed {
    logic count_pause;
    clk_sel_t clock_source_select;
    logic timer_on;
    logic [2:0] period_compare_value;
  } ctrl0_t;

  typedef struct packed {
    mode_t operating_mode_select;
    logic [1:0] output_function_select;
    logic output_initial_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } ctrl1_t;
endpackage

// ==== src/ctm_timer.sv ====
// compact 10-bit timer with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer
  import ctm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic high_speed_clock_tick,
  input wire logic time_base_clock_tick,
  input wire logic external_count_input,
  output logic timer_output_pin_a,
  output logic timer_output_pin_b,
  output logic timer_output_pin_c,
  output logic compare_a_flag,
  output logic compare_p_flag
);
  ctrl0_t ctrl0_q;
  ctrl1_t ctrl1_q;
  logic [9:0] cnt_q;
  logic [9:0] cmpa_q;
  logic [7:0] buf_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic on_q;
  logic out_q;
  logic aflag_q, pflag_q;
  logic [3:0] div4_q;
  logic [3:0] div16_q;
  logic [5:0] div64_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic hs_s1_q, hs_s2_q, hs_s3_q;
  logic tb_s1_q, tb_s2_q, tb_s3_q;
  logic tick, match_a, match_p, overflow, clear_cnt;
  logic on_rise, wr, rd, rd_cap;
  logic hs_edge, tb_edge;

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // one wait cycle; side effects land only at the edge that sees waitrequest low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr = avs_write & ack_q;
  assign rd = avs_read & ack_q;
  // read data captured a cycle early so it already stands at the accepting edge
  assign rd_cap = avs_read & ~ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // pins from outside pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      hs_s1_q <= 1'b0;
      hs_s2_q <= 1'b0;
      hs_s3_q <= 1'b0;
      tb_s1_q <= 1'b0;
      tb_s2_q <= 1'b0;
      tb_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      hs_s1_q <= high_speed_clock_tick;
      hs_s2_q <= hs_s1_q;
      hs_s3_q <= hs_s2_q;
      tb_s1_q <= time_base_clock_tick;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
    end
  end

  assign hs_edge = rise(hs_s2_q, hs_s3_q);
  assign tb_edge = rise(tb_s2_q, tb_s3_q);

  // prescalers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div4_q <= 4'h0;
      div16_q <= 4'h0;
      div64_q <= 6'h00;
    end else begin
      div4_q <= (div4_q == DIV4_LAST) ? 4'h0 : div4_q + 4'h1;
      if (hs_edge) begin
        div16_q <= div16_q + 4'h1;
        div64_q <= div64_q + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (ctrl0_q.clock_source_select)
      CK_SYS_DIV4: tick = (div4_q == DIV4_LAST);
      CK_SYS: tick = 1'b1;
      CK_HIGH_DIV16: tick = hs_edge && (div16_q == DIV16_LAST);
      CK_HIGH_DIV64: tick = hs_edge && (div64_q == DIV64_LAST);
      CK_TBC: tick = tb_edge;
      CK_UNDEF: tick = 1'b0;
      CK_PIN_RISE: tick = rise(ext_s2_q, ext_s3_q);
      CK_PIN_FALL: tick = rise(ext_s3_q, ext_s2_q);
    endcase
  end

  // match detection, evaluated on the counter's next value
  logic [9:0] cnt_inc;
  logic [9:0] period_lim;
  logic pwm;
  assign pwm = (ctrl1_q.operating_mode_select == MODE_PWM);
  assign cnt_inc = cnt_q + CNT_ONE;
  assign period_lim = {ctrl0_q.period_compare_value, 7'h00};
  assign match_a = (cnt_inc == cmpa_q) && (cmpa_q != 10'h000);
  assign match_p = (ctrl0_q.period_compare_value != PERIOD_OVF) &&
                   (cnt_inc == period_lim);
  assign overflow = (cnt_q == CNT_MAX);

  always_comb begin
    if (pwm) begin
      // clear select ignored; picks the period source
      clear_cnt = ctrl1_q.period_duty_swap ? match_a : (match_p | overflow);
    end else if (ctrl1_q.clear_source_select) begin
      clear_cnt = match_a | overflow;
    end else begin
      clear_cnt = match_p | overflow;
    end
  end

  logic run;
  assign run = ctrl0_q.timer_on && !ctrl0_q.count_pause && tick;
  assign on_rise = rise(ctrl0_q.timer_on, on_q);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      on_q <= 1'b0;
    end else begin
      on_q <= ctrl0_q.timer_on;
    end
  end

  // counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 10'h000;
    end else if (on_rise) begin
      cnt_q <= 10'h000;
    end else if (run) begin
      cnt_q <= clear_cnt ? 10'h000 : cnt_inc;
    end
    // otherwise holds: pause or off keeps the value
  end

  // flags, set beats software clear
  logic a_set, p_set;
  assign a_set = run && match_a;
  assign p_set = run && match_p && (pwm || !ctrl1_q.clear_source_select);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aflag_q <= 1'b0;
      pflag_q <= 1'b0;
    end else begin
      if (a_set) begin
        aflag_q <= 1'b1;
      end else if (wr && avs_address == ADDR_FLAGS && avs_writedata[0]) begin
        aflag_q <= 1'b0;
      end
      if (p_set) begin
        pflag_q <= 1'b1;
      end else if (wr && avs_address == ADDR_FLAGS && avs_writedata[1]) begin
        pflag_q <= 1'b0;
      end
    end
  end
  assign compare_a_flag = aflag_q;
  assign compare_p_flag = pflag_q;

  // output level before inversion
  logic pwm_active;
  always_comb begin
    if (ctrl1_q.period_duty_swap) begin
      pwm_active = (ctrl0_q.period_compare_value == PERIOD_OVF) ||
                   (cnt_q < period_lim);
    end else begin
      pwm_active = (cnt_q < cmpa_q) ||
                   ((ctrl0_q.period_compare_value != PERIOD_OVF) &&
                    (cmpa_q >= period_lim));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 1'b0;
    end else if (ctrl1_q.operating_mode_select == MODE_CMP) begin
      if (on_rise) begin
        out_q <= ctrl1_q.output_initial_level;
      end else if (a_set) begin
        unique case (ctrl1_q.output_function_select)
          2'h0: out_q <= out_q;
          2'h1: out_q <= 1'b0;
          2'h2: out_q <= 1'b1;
          2'h3: out_q <= ~out_q;
        endcase
      end
    end else if (pwm) begin
      unique case (ctrl1_q.output_function_select)
        2'h0: out_q <= ~ctrl1_q.output_initial_level;
        2'h1: out_q <= ctrl1_q.output_initial_level;
        2'h2: out_q <= pwm_active ? ctrl1_q.output_initial_level
                                  : ~ctrl1_q.output_initial_level;
        2'h3: out_q <= out_q;
      endcase
    end
  end

  logic pin;
  // timer mode leaves the pin idle; pin sharing is outside this block
  assign pin = (ctrl1_q.operating_mode_select == MODE_TIMER) ? 1'b0
             : out_q ^ ctrl1_q.output_invert;
  assign timer_output_pin_a = pin;
  assign timer_output_pin_b = pin;
  assign timer_output_pin_c = pin;

  // register writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_q <= ctrl0_t'(CTRL_RESET);
      ctrl1_q <= ctrl1_t'(CTRL_RESET);
      cmpa_q <= 10'h000;
    end else if (wr) begin
      if (avs_address == ADDR_CTRL0) begin
        ctrl0_q <= ctrl0_t'(avs_writedata);
      end
      if (avs_address == ADDR_CTRL1) begin
        ctrl1_q <= ctrl1_t'(avs_writedata);
      end
      if (avs_address == ADDR_CMPA_HI) begin
        cmpa_q <= {avs_writedata[1:0], buf_q};
      end
    end
  end

  // shared 8-bit holding buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      buf_q <= 8'h00;
    end else if (wr && avs_address == ADDR_CMPA_LO) begin
      buf_q <= avs_writedata;
    end else if (rd && avs_address == ADDR_CNT_HI) begin
      buf_q <= cnt_q[7:0];
    end else if (rd && avs_address == ADDR_CMPA_HI) begin
      buf_q <= cmpa_q[7:0];
    end
  end

  // read data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd_cap) begin
      unique case (avs_address)
        ADDR_CTRL0: rdata_q <= ctrl0_q;
        ADDR_CTRL1: rdata_q <= ctrl1_q;
        ADDR_CNT_LO: rdata_q <= buf_q;
        ADDR_CNT_HI: rdata_q <= {6'h00, cnt_q[9:8]};
        ADDR_CMPA_LO: rdata_q <= buf_q;
        ADDR_CMPA_HI: rdata_q <= {6'h00, cmpa_q[9:8]};
        ADDR_FLAGS: rdata_q <= {6'h00, pflag_q, aflag_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
endmodule // ctm_timer
`default_nettype wire

// ==== dv/ctm_timer_sva.sv ====
// checker for the compact timer register bus, pins and flags
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_sva
  import ctm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timer_output_pin_a,
  input wire logic timer_output_pin_b,
  input wire logic timer_output_pin_c,
  input wire logic compare_a_flag,
  input wire logic compare_p_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 3'h7
    |-> avs_readdata == 8'h00) else $error("unmapped read not zero");
  a_high_unused: assert property (avs_read && !avs_waitrequest && (avs_address == ADDR_CNT_HI
    || avs_address == ADDR_CMPA_HI) |-> avs_readdata[7:2] == 6'h00)
    else $error("unused high bits not zero");
  a_pins_same: assert property (timer_output_pin_a == timer_output_pin_b
    && timer_output_pin_a == timer_output_pin_c) else $error("output pins differ");
  a_flag_a_sticky: assert property (compare_a_flag && !(avs_write && !avs_waitrequest
    && avs_address == ADDR_FLAGS && avs_writedata[0]) |=> compare_a_flag)
    else $error("flag a dropped without clear");
  a_flag_p_sticky: assert property (compare_p_flag && !(avs_write && !avs_waitrequest
    && avs_address == ADDR_FLAGS && avs_writedata[1]) |=> compare_p_flag)
    else $error("flag p dropped without clear");
  a_read_stands: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
endmodule // ctm_timer_sva
bind ctm_timer ctm_timer_sva ctm_timer_sva_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_output_pin_a(timer_output_pin_a),
  .timer_output_pin_b(timer_output_pin_b), .timer_output_pin_c(timer_output_pin_c),
  .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ctm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic pin_a, pin_b, pin_c, flag_a, flag_p;
  logic [7:0] q, h;
  logic [9:0] cnt, c0;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  // only the system clock source is exercised; tick and pin inputs tied
  ctm_timer ctm_timer_i (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .high_speed_clock_tick(1'b0), .time_base_clock_tick(1'b0), .external_count_input(1'b0),
    .timer_output_pin_a(pin_a), .timer_output_pin_b(pin_b), .timer_output_pin_c(pin_c),
    .compare_a_flag(flag_a), .compare_p_flag(flag_p));
  task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done();
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // request held until an edge samples waitrequest low; data taken at that edge
  task bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    logic w;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    w = 1'b1;
    while (w) begin
      @(posedge clk_sys);
      w = (avs_waitrequest !== 1'b0);
      q = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd_cnt();
    bus(1'b0, ADDR_CNT_HI, 8'h00);
    h = q;
    bus(1'b0, ADDR_CNT_LO, 8'h00);
    cnt = {h[1:0], q};
  endtask
  task wait_pin(input logic v);
    repeat (300) if (pin_a !== v) @(posedge clk_sys);
  endtask
  task t_reset();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, i[2:0], 8'h00);
      check("reset read", {2'b00, q}, 10'h000);
    end
  endtask
  task t_compare();
    bus(1'b1, ADDR_CTRL1, 8'h21);
    bus(1'b1, ADDR_CMPA_LO, 8'h05);
    bus(1'b1, ADDR_CMPA_HI, 8'h00);
    // a lone low write must stay in the buffer
    bus(1'b1, ADDR_CMPA_LO, 8'h09);
    bus(1'b0, ADDR_CMPA_HI, 8'h00);
    bus(1'b0, ADDR_CMPA_LO, 8'h00);
    check("compare low", {2'b00, q}, 10'h005);
    bus(1'b1, ADDR_CMPA_HI, 8'h00);
    bus(1'b1, ADDR_CTRL0, 8'h18);
    wait_pin(1'b1);
    check("pin driven high", {9'h000, pin_a}, 10'h001);
    rd_cnt();
    check("count below a", {9'h000, cnt < 10'h005}, 10'h001);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    check("flags clear on a", {8'h00, q[1:0]}, 10'h001);
  endtask
  task t_pause();
    bus(1'b1, ADDR_CTRL0, 8'h98);
    rd_cnt();
    c0 = cnt;
    repeat (20) @(posedge clk_sys);
    rd_cnt();
    check("paused count", cnt, c0);
  endtask
  task t_restart();
    bus(1'b1, ADDR_CTRL0, 8'h90);
    bus(1'b1, ADDR_CTRL0, 8'h98);
    rd_cnt();
    check("count after on", cnt, 10'h000);
    check("pin back to initial", {9'h000, pin_a}, 10'h000);
    bus(1'b1, ADDR_CTRL0, 8'h18);
    wait_pin(1'b1);
    check("pin high after resume", {9'h000, pin_a}, 10'h001);
    bus(1'b1, ADDR_CTRL0, 8'h90);
    bus(1'b1, ADDR_CTRL1, 8'h1d);
    bus(1'b1, ADDR_CTRL0, 8'h98);
    check("inverted initial", {9'h000, pin_a}, 10'h000);
    bus(1'b1, ADDR_CTRL0, 8'h18);
    wait_pin(1'b1);
    check("inverted low drive", {9'h000, pin_a}, 10'h001);
  endtask
  task t_timer();
    bus(1'b1, ADDR_CTRL0, 8'h10);
    bus(1'b1, ADDR_CTRL1, 8'hc0);
    bus(1'b1, ADDR_FLAGS, 8'h03);
    check("timer mode pin", {9'h000, pin_a}, 10'h000);
    bus(1'b1, ADDR_CTRL0, 8'h19);
    repeat (100) @(posedge clk_sys);
    check("p flag early", {9'h000, flag_p}, 10'h000);
    repeat (200) if (flag_p !== 1'b1) @(posedge clk_sys);
    check("p flag at 128", {9'h000, flag_p}, 10'h001);
    rd_cnt();
    check("cleared on p", {9'h000, cnt < 10'h010}, 10'h001);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_compare();
    t_pause();
    t_restart();
    t_timer();
    test_done();
  end
endmodule // testbench
`default_nettype wire
